// ---- verilog/dcf_pkg.sv ----
// Purpose: Shared constants for the flagged FIFO block
// Assumes: One system clock, pin-side clocks far slower than it
// Notes:   Offsets are loaded as two 9-bit words each

`default_nettype none

package dcf_pkg;

  // ********************
  // Data and depth
  // ********************
  localparam int DCF_DATA_W      = 9;
  localparam int DCF_ADDR_W_DEF  = 14;
  localparam int DCF_RAW_W       = 2 * DCF_DATA_W;

  // ********************
  // Flag offsets after reset
  // ********************
  localparam int DCF_AE_DEFAULT  = 7;
  localparam int DCF_AF_DEFAULT  = 7;

  // ********************
  // Pin synchroniser bundle
  // ********************
  localparam int DCF_PIN_CTRL_W  = 7;
  localparam int DCF_PIN_W       = DCF_PIN_CTRL_W + DCF_DATA_W;
  localparam int DCF_BIT_WCLK    = 0;
  localparam int DCF_BIT_RCLK    = 1;
  localparam int DCF_BIT_RST_N   = 2;
  localparam int DCF_BIT_WRITE_ENABLE_PRIMARY_N_N  = 3;
  localparam int DCF_BIT_WEN2    = 4;
  localparam int DCF_BIT_RENA_N  = 5;
  localparam int DCF_BIT_RENB_N  = 6;
  localparam int DCF_BIT_DATA    = 7;

  // ********************
  // Offset load sequence
  // ********************
  typedef enum logic [1:0] {
    DCF_LD_AE_LO = 2'b00,
    DCF_LD_AE_HI = 2'b01,
    DCF_LD_AF_LO = 2'b10,
    DCF_LD_AF_HI = 2'b11
  } dcf_load_t;

endpackage

`default_nettype wire

// ---- verilog/dcf_fifo.sv ----
// Purpose: 9-bit first-in first-out buffer with four status flags
// Assumes: Pin clocks run at most a quarter of clock_i
// Notes:   Pin clocks are sampled, so all logic stays on clock_i

`timescale 1ns/1ps
`default_nettype none

module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int ADDR_W = DCF_ADDR_W_DEF
) (
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire logic                  write_clock_i,
  input  wire logic                  read_clock_i,
  input  wire logic                  master_reset_n_i,
  input  wire logic                  write_enable_primary_n_i,
  input  wire logic                  write_enable_or_offset_load_i,
  input  wire logic                  read_enable_a_n_i,
  input  wire logic                  read_enable_b_n_i,
  input  wire logic [DCF_DATA_W-1:0] write_word_i,
  output logic      [DCF_DATA_W-1:0] read_word_o,
  output logic                       empty_indicator_n_o,
  output logic                       full_indicator_n_o,
  output logic                       almost_empty_indicator_n_o,
  output logic                       almost_full_indicator_n_o
);

  // ********************
  // Sizes
  // ********************
  localparam int CNT_W = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [CNT_W-1:0]    DEPTH_C = CNT_W'(DEPTH);
  localparam logic [DCF_RAW_W-1:0] AE_RST = DCF_RAW_W'(DCF_AE_DEFAULT);
  localparam logic [DCF_RAW_W-1:0] AF_RST = DCF_RAW_W'(DCF_AF_DEFAULT);

  // ********************
  // Pin synchronisers
  // ********************
  logic [DCF_PIN_W-1:0] pins;
  logic [DCF_PIN_W-1:0] sync1_r;
  logic [DCF_PIN_W-1:0] sync2_r;

  assign pins = {write_word_i, read_enable_b_n_i, read_enable_a_n_i,
                 write_enable_or_offset_load_i, write_enable_primary_n_i,
                 master_reset_n_i, read_clock_i, write_clock_i};

  genvar gi;
  generate
    for (gi = 0; gi < DCF_PIN_W; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        sync1_r[gi] <= pins[gi];
        sync2_r[gi] <= sync1_r[gi];
      end
    end
  endgenerate

  logic                  wclk_s;
  logic                  rclk_s;
  logic                  rst_n_s;
  logic                  write_enable_primary_n_n_s;
  logic                  wen2_s;
  logic                  rena_n_s;
  logic                  renb_n_s;
  logic [DCF_DATA_W-1:0] data_s;

  assign wclk_s   = sync2_r[DCF_BIT_WCLK];
  assign rclk_s   = sync2_r[DCF_BIT_RCLK];
  assign rst_n_s  = sync2_r[DCF_BIT_RST_N];
  assign write_enable_primary_n_n_s = sync2_r[DCF_BIT_WRITE_ENABLE_PRIMARY_N_N];
  assign wen2_s   = sync2_r[DCF_BIT_WEN2];
  assign rena_n_s = sync2_r[DCF_BIT_RENA_N];
  assign renb_n_s = sync2_r[DCF_BIT_RENB_N];
  assign data_s   = sync2_r[DCF_BIT_DATA +: DCF_DATA_W];

  // ********************
  // Pin clock edges and reset
  // ********************
  logic wclk_d_r;
  logic rclk_d_r;
  logic rst_all;
  logic wr_edge;
  logic rd_edge;

  always_ff @(posedge clock_i) begin
    wclk_d_r <= wclk_s;
    rclk_d_r <= rclk_s;
  end

  assign rst_all = reset_i | ~rst_n_s;
  assign wr_edge = wclk_s & ~wclk_d_r;
  assign rd_edge = rclk_s & ~rclk_d_r;

  // ********************
  // Role of the dual pin
  // ********************
  logic two_enable_r;

  always_ff @(posedge clock_i) begin
    if (rst_all) begin
      two_enable_r <= wen2_s;
    end
  end

  // ********************
  // Transfer decode
  // ********************
  logic empty_n_r;
  logic full_n_r;
  logic ae_n_r;
  logic af_n_r;
  logic wr_req;
  logic wr_do;
  logic ld_do;
  logic rd_req;
  logic rd_do;

  assign wr_req = wr_edge & ~write_enable_primary_n_n_s & wen2_s;
  assign wr_do  = wr_req & full_n_r;
  assign ld_do  = wr_edge & ~two_enable_r & ~write_enable_primary_n_n_s & ~wen2_s;
  assign rd_req = rd_edge & ~rena_n_s & ~renb_n_s;
  assign rd_do  = rd_req & empty_n_r;

  // ********************
  // Pointers and fill count
  // ********************
  logic [ADDR_W-1:0] wptr_r;
  logic [ADDR_W-1:0] rptr_r;
  logic [CNT_W-1:0]  count_r;
  logic [CNT_W-1:0]  count_nxt;

  assign count_nxt = count_r + CNT_W'(wr_do) - CNT_W'(rd_do);

  always_ff @(posedge clock_i) begin
    if (rst_all) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      wptr_r  <= wptr_r + ADDR_W'(wr_do);
      rptr_r  <= rptr_r + ADDR_W'(rd_do);
      count_r <= count_nxt;
    end
  end

  // ********************
  // Storage
  // ********************
  logic [DCF_DATA_W-1:0] mem [DEPTH];
  logic [DCF_DATA_W-1:0] read_word_r;

  always_ff @(posedge clock_i) begin
    if (wr_do) begin
      mem[wptr_r] <= data_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_all) begin
      read_word_r <= '0;
    end else if (rd_do) begin
      read_word_r <= mem[rptr_r];
    end
  end

  assign read_word_o = read_word_r;

  // ********************
  // Offset loading
  // ********************
  dcf_load_t            step_r;
  dcf_load_t            step_nxt;
  logic [DCF_RAW_W-1:0] ae_raw_r;
  logic [DCF_RAW_W-1:0] af_raw_r;
  logic [ADDR_W-1:0]    ae_off;
  logic [ADDR_W-1:0]    af_off;
  logic [CNT_W-1:0]     af_level;

  always_comb begin
    case (step_r)
      DCF_LD_AE_LO: step_nxt = DCF_LD_AE_HI;
      DCF_LD_AE_HI: step_nxt = DCF_LD_AF_LO;
      DCF_LD_AF_LO: step_nxt = DCF_LD_AF_HI;
      DCF_LD_AF_HI: step_nxt = DCF_LD_AE_LO;
      default:      step_nxt = DCF_LD_AE_LO;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_all) begin
      step_r   <= DCF_LD_AE_LO;
      ae_raw_r <= AE_RST;
      af_raw_r <= AF_RST;
    end else if (ld_do) begin
      step_r <= step_nxt;
      case (step_r)
        DCF_LD_AE_LO: ae_raw_r[DCF_DATA_W-1:0]         <= data_s;
        DCF_LD_AE_HI: ae_raw_r[DCF_RAW_W-1:DCF_DATA_W] <= data_s;
        DCF_LD_AF_LO: af_raw_r[DCF_DATA_W-1:0]         <= data_s;
        DCF_LD_AF_HI: af_raw_r[DCF_RAW_W-1:DCF_DATA_W] <= data_s;
        default:      ae_raw_r                         <= ae_raw_r;
      endcase
    end
  end

  assign ae_off   = ae_raw_r[ADDR_W-1:0];
  assign af_off   = af_raw_r[ADDR_W-1:0];
  assign af_level = DEPTH_C - CNT_W'(af_off);

  // ********************
  // Status flags
  // ********************
  always_ff @(posedge clock_i) begin
    if (rst_all) begin
      empty_n_r <= 1'b0;
      ae_n_r    <= 1'b0;
    end else if (rd_edge) begin
      empty_n_r <= count_nxt != '0;
      ae_n_r    <= count_nxt > CNT_W'(ae_off);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_all) begin
      full_n_r <= 1'b1;
      af_n_r   <= 1'b1;
    end else if (wr_edge) begin
      full_n_r <= count_nxt != DEPTH_C;
      af_n_r   <= count_nxt < af_level;
    end
  end

  assign empty_indicator_n_o        = empty_n_r;
  assign full_indicator_n_o         = full_n_r;
  assign almost_empty_indicator_n_o = ae_n_r;
  assign almost_full_indicator_n_o  = af_n_r;

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_all);

  chk_full_blocks_write: assert property (
    !full_n_r && wr_req |=> $stable(wptr_r) && count_r <= $past(count_r))
    else $error("write stored while full");

  chk_empty_read_edge: assert property (
    $changed(empty_n_r) || $changed(ae_n_r) |-> $past(rd_edge))
    else $error("empty flags moved off a read edge");

  chk_full_write_edge: assert property (
    $changed(full_n_r) || $changed(af_n_r) |-> $past(wr_edge))
    else $error("full flags moved off a write edge");

  chk_empty_hold_one: assert property (
    $changed(empty_n_r) || $changed(ae_n_r) |=> $stable(empty_n_r) && $stable(ae_n_r))
    else $error("empty flags did not hold one cycle");

  chk_full_hold_one: assert property (
    $changed(full_n_r) || $changed(af_n_r) |=> $stable(full_n_r) && $stable(af_n_r))
    else $error("full flags did not hold one cycle");

  chk_write_each_edge: assert property (
    wr_req && full_n_r && !rd_do |=> count_r == $past(count_r) + 1'b1)
    else $error("enabled write not stored");

  chk_read_when_empty: assert property (
    rd_req && !empty_n_r |=> $stable(read_word_r) && $stable(rptr_r))
    else $error("read taken while empty");

  chk_full_level: assert property (
    wr_edge |=> full_n_r == (count_r != DEPTH_C))
    else $error("full flag wrong after write edge");

  chk_ae_threshold: assert property (
    rd_edge |=> ae_n_r == (count_r > CNT_W'($past(ae_off))))
    else $error("almost-empty flag wrong after read edge");

  chk_reset_empty: assert property (
    disable iff (1'b0) rst_all |=> count_r == '0 && !empty_n_r && full_n_r)
    else $error("reset did not empty the buffer");

endmodule

`default_nettype wire

// ---- verification/dcf_pin_partner.sv ----
// Purpose: Pin-side writer and reader for the flagged FIFO
// Assumes: Pin clocks derived from clock_i at slow ratios
// Notes:   Enables and data change at pin clock falling edges
`timescale 1ns/1ps
`default_nettype none
module dcf_pin_partner
  import dcf_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  tie_i,
  input  wire logic                  wr_go_i,
  input  wire logic                  wr_p_n_i,
  input  wire logic                  wr_dual_i,
  input  wire logic [DCF_DATA_W-1:0] wr_data_i,
  input  wire logic                  rd_a_n_i,
  input  wire logic                  rd_b_n_i,
  output logic                       wclk_o,
  output logic                       rclk_o,
  output logic                       wen_n_o,
  output logic                       dual_o,
  output logic      [DCF_DATA_W-1:0] data_o,
  output logic                       ren_a_n_o,
  output logic                       ren_b_n_o
);
  logic [2:0] wcnt_r = 3'h0;
  logic [3:0] rcnt_r = 4'h0;
  initial begin
    {wclk_o, rclk_o, wen_n_o, dual_o, ren_a_n_o, ren_b_n_o} = 6'h0f;
    data_o = '0;
  end
  // Free-running pin clocks, 80 ns and 100 ns, or one shared 80 ns clock
  always @(posedge clock_i) begin
    #1;
    wcnt_r <= wcnt_r + 3'h1;
    rcnt_r <= (rcnt_r == 4'h9) ? 4'h0 : rcnt_r + 4'h1;
    wclk_o <= wcnt_r[2];
    rclk_o <= tie_i ? wcnt_r[2] : (rcnt_r > 4'h4);
  end
  // Idle bus shows inverted data, second enable stays high
  always @(negedge wclk_o) begin
    wen_n_o <= wr_go_i ? wr_p_n_i : 1'b1;
    dual_o  <= wr_go_i ? wr_dual_i : 1'b1;
    data_o  <= wr_go_i ? wr_data_i : ~data_o;
  end
  always @(negedge rclk_o) begin
    ren_a_n_o <= rd_a_n_i;
    ren_b_n_o <= rd_b_n_i;
  end
endmodule
`default_nettype wire

// ---- verification/test_dual_clock_flagged_fifo.sv ----
// Purpose: Self-checking bench for the flagged FIFO
// Assumes: Depth cut to 16 words through ADDR_W
// Notes:   Queue model gives expected words and flags
`timescale 1ns/1ps
`default_nettype none
module test_dual_clock_flagged_fifo
  import dcf_pkg::*;
;
  localparam int DEPTH = 16;
  logic clock_i = 0, reset_i = 1, mrst_n = 1, wr_go = 0, wr_p_n = 1, wr_dual = 1;
  logic rd_a_n = 1, rd_b_n = 1, wclk, rclk, wen_n, dual, ren_a, ren_b;
  logic e_n, f_n, ae_n, af_n, tie = 0;
  logic [DCF_DATA_W-1:0] wr_data = '0, din, q_o, last = '0;
  logic [DCF_DATA_W-1:0] q[$];
  int bad_count = 0, checks = 0, seed = 32'heb4e5b99;
  int ae_exp = DCF_AE_DEFAULT, af_exp = DCF_AF_DEFAULT;
  always #5 clock_i = ~clock_i;
  dcf_pin_partner i_dcf_pin_partner (.clock_i(clock_i), .tie_i(tie), .wr_go_i(wr_go),
    .wr_p_n_i(wr_p_n), .wr_dual_i(wr_dual), .wr_data_i(wr_data), .rd_a_n_i(rd_a_n),
    .rd_b_n_i(rd_b_n),
    .wclk_o(wclk), .rclk_o(rclk), .wen_n_o(wen_n), .dual_o(dual), .data_o(din),
    .ren_a_n_o(ren_a), .ren_b_n_o(ren_b));
  dcf_fifo #(.ADDR_W(4)) i_dcf_fifo (.clock_i(clock_i), .reset_i(reset_i),
    .write_clock_i(wclk), .read_clock_i(rclk), .master_reset_n_i(mrst_n),
    .write_enable_primary_n_i(wen_n), .write_enable_or_offset_load_i(dual),
    .read_enable_a_n_i(ren_a), .read_enable_b_n_i(ren_b), .write_word_i(din),
    .read_word_o(q_o), .empty_indicator_n_o(e_n), .full_indicator_n_o(f_n),
    .almost_empty_indicator_n_o(ae_n), .almost_full_indicator_n_o(af_n));
  function automatic logic [3:0] exp_flags(input int n);
    return {n != 0, n > ae_exp, n != DEPTH, n < DEPTH - af_exp};
  endfunction
  task automatic cmp_word(input logic [DCF_DATA_W-1:0] g, input logic [DCF_DATA_W-1:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_flags(input logic [3:0] g, input logic [3:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic p_n, input logic du);
    wr_go = 1;
    wr_p_n = p_n;
    wr_dual = du;
    wr_data = DCF_DATA_W'($random(seed));
    @(negedge wclk);
    @(posedge wclk);
    if (!p_n && du && q.size() < DEPTH) q.push_back(wr_data);
  endtask
  task automatic wrn(input int n);
    repeat (n) wr(1'b0, 1'b1);
    wr_go = 0;
  endtask
  task automatic rd(input logic a, input logic b);
    logic [DCF_DATA_W-1:0] e;
    e = last;
    rd_a_n = a;
    rd_b_n = b;
    @(negedge rclk);
    @(posedge rclk);
    if (!a && !b && q.size() > 0) e = q.pop_front();
    last = e;
    repeat (3) @(posedge clock_i);
    #2;
    cmp_word(q_o, e);
  endtask
  task automatic rdn(input int n);
    repeat (n) rd(1'b0, 1'b0);
    rd_a_n = 1;
    rd_b_n = 1;
  endtask
  task automatic settle_check;
    repeat (30) @(posedge clock_i);
    #2;
    cmp_flags({e_n, ae_n, f_n, af_n}, exp_flags(q.size()));
  endtask
  task automatic finish_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (20) @(posedge clock_i);
    #1 reset_i = 0;
    repeat (5) @(posedge clock_i);
    #2 cmp_word(q_o, '0);
    settle_check;
    wrn(7); settle_check;
    wr(1'b1, 1'b1); wr(1'b0, 1'b0); wr_go = 0; settle_check;
    wrn(1); settle_check;
    wrn(1); settle_check;
    fork wrn(5); rdn(5); join
    settle_check;
    tie = 1;
    repeat (20) @(posedge clock_i);
    #1 fork wrn(4); rdn(4); join
    tie = 0;
    settle_check;
    wrn(7); settle_check;
    wrn(2); settle_check;
    rd(1'b0, 1'b1); rd(1'b1, 1'b0); rdn(0); settle_check;
    rdn(16); settle_check;
    rd(1'b0, 1'b0); rdn(0);
    wrn(3);
    @(posedge clock_i) #1 mrst_n = 0;
    repeat (5) @(posedge clock_i);
    #1 mrst_n = 1;
    q.delete();
    settle_check;
    cmp_word(q_o, '0);
    // Dual pin held low through reset selects offset loading
    wr_go = 1;
    wr_p_n = 1;
    wr_dual = 0;
    @(negedge wclk);
    repeat (4) @(posedge clock_i);
    #1 mrst_n = 0;
    repeat (5) @(posedge clock_i);
    #1 mrst_n = 1;
    repeat (4) @(posedge clock_i);
    settle_check;
    wr(1'b0, 1'b0);
    ae_exp = wr_data % DEPTH;
    wr(1'b0, 1'b0);
    wr(1'b0, 1'b0);
    af_exp = wr_data % DEPTH;
    wr(1'b0, 1'b0);
    repeat (DEPTH) begin
      wrn(1);
      settle_check;
    end
    finish_test;
  end
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end
endmodule
`default_nettype wire
